/* File: core/gsl_indicator.sv */
// gateway status indicator top: transaction events to LED drives
`include "gsl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module gsl_indicator #(
    parameter int unsigned PULSE_CYC = `GSL_PULSE_CYC,
    parameter int unsigned HB_PERIOD_CYC = `GSL_HB_PERIOD_CYC,
    parameter int unsigned HB_OFF_CYC = `GSL_HB_OFF_CYC,
    parameter int unsigned PWRUP_CYC = `GSL_PWRUP_CYC,
    parameter int unsigned ERR_FLASH_CYC = `GSL_ERR_FLASH_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic MASTER_REQ_SENT,
    input wire logic MASTER_RSP_GOOD,
    input wire logic MASTER_RSP_EXC,
    input wire logic MASTER_RSP_TIMEOUT,
    input wire logic SLAVE_REQ_RCVD,
    input wire logic SLAVE_RSP_GOOD,
    input wire logic SLAVE_RSP_EXC,
    input wire logic SLAVE_CRC_ERR,
    input wire logic RTU_MODE,
    input wire logic TCP_CONN_FAIL,
    input wire logic ETH_TRAFFIC,
    input wire logic SERVER_RUNNING,
    input wire logic ETH_LINK,
    input wire logic SERVICE_MSG_TX,
    input wire logic FIELDBUS_TX,
    input wire logic FIELDBUS_RX,
    input wire logic HW_FAULT,
    input wire logic USB_CONNECTED,
    input wire logic UPDATE_STRAP,
    output gsl_pkg::gsl_color_t REQUEST_LED,
    output gsl_pkg::gsl_color_t REPLY_LED,
    output logic ETH_TRAFFIC_LED,
    output logic ETH_LINK_LED,
    output logic SERVICE_LED,
    output logic FIELDBUS_TRANSMIT_INDICATOR,
    output logic FIELDBUS_RECEIVE_INDICATOR,
    output logic STATE_LED,
    output logic ERROR_LED,
    output logic USB_LED,
    output logic UPDATE_MODE
);
    import gsl_pkg::*;

    // ****************************************************************
    // reset release and pin synchronisation
    // ****************************************************************
    logic rst_s1_q;
    logic rst_q;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // the link, server, usb, fault and strap levels come from other chips
    logic [5:0] lvl;
    gsl_sync #(.W(6)) u_sync (
        .clk(CLK_SYS),
        .rst_b(rst_q),
        .d({UPDATE_STRAP, HW_FAULT, USB_CONNECTED, ETH_LINK, SERVER_RUNNING, RTU_MODE}),
        .q(lvl)
    );
    logic strap_s;
    logic fault_s;
    logic usb_s;
    logic link_s;
    logic server_s;
    logic rtu_s;
    assign {strap_s, fault_s, usb_s, link_s, server_s, rtu_s} = lvl;

    // ****************************************************************
    // event decode and pulse stretching
    // ****************************************************************
    // strobes come from engines on this clock, so they skip the synchroniser
    logic ev_req;
    logic ev_good;
    logic ev_bad;
    assign ev_req = MASTER_REQ_SENT | SLAVE_REQ_RCVD;
    assign ev_good = MASTER_RSP_GOOD | SLAVE_RSP_GOOD;
    // crc errors only count on the serial line; connect failures never touch request
    assign ev_bad = MASTER_RSP_EXC | MASTER_RSP_TIMEOUT
                  | SLAVE_RSP_EXC | (SLAVE_CRC_ERR & rtu_s)
                  | TCP_CONN_FAIL;

    logic [6:0] trig;
    logic [6:0] lit;
    assign trig = {ev_req, ev_good, ev_bad, ETH_TRAFFIC, SERVICE_MSG_TX, FIELDBUS_TX,
                   FIELDBUS_RX};
    // the show colours override the request and reply pulses during power-up, yet the counters keep running
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_str
            gsl_stretch #(.CYCLES(PULSE_CYC)) u_str (
                .clk(CLK_SYS),
                .rst_b(rst_q),
                .trig(trig[gi]),
                .lit(lit[gi])
            );
        end
    endgenerate
    logic req_lit;
    logic good_lit;
    logic bad_lit;
    logic traf_lit;
    logic svc_lit;
    logic tx_lit;
    logic rx_lit;
    assign {req_lit, good_lit, bad_lit, traf_lit, svc_lit, tx_lit, rx_lit} = lit;

    // ****************************************************************
    // system sequencing: power-up show, heartbeat, update mode
    // ****************************************************************
    localparam int unsigned CW = $clog2(HB_PERIOD_CYC + PWRUP_CYC + 1);
    gsl_state_t st_q;
    logic [CW-1:0] tmr_q;
    logic [3:0] blink_q;
    logic strap_seen_q;

    // last cycle of a timed phase
    function automatic logic phase_end(input logic [CW-1:0] t, input int unsigned len);
        return t == CW'(len - 1);
    endfunction

    // a failure outranks a success, so a failure in the same interval is never hidden
    function automatic gsl_color_t pick_color(input logic red, input logic green,
                                              input logic yellow);
        if (red) begin
            return GSL_RED;
        end
        if (green) begin
            return GSL_GREEN;
        end
        return yellow ? GSL_YELLOW : GSL_OFF;
    endfunction

    // strap is caught once, the first cycle its synchronised copy is valid
    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            strap_seen_q <= 1'b0;
            UPDATE_MODE <= 1'b0;
        end else if (!strap_seen_q && st_q == GSL_S_PWR_RED
                     && tmr_q == CW'(`GSL_STRAP_SAMPLE_CYC)) begin
            strap_seen_q <= 1'b1;
            UPDATE_MODE <= strap_s;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= GSL_S_PWR_RED;
            tmr_q <= '0;
            blink_q <= '0;
        end else begin
            tmr_q <= tmr_q + 1'b1;
            case (st_q)
                GSL_S_PWR_RED: begin
                    if (phase_end(tmr_q, PWRUP_CYC)) begin
                        tmr_q <= '0;
                        st_q <= GSL_S_PWR_GREEN;
                    end
                end
                GSL_S_PWR_GREEN: begin
                    if (phase_end(tmr_q, PWRUP_CYC)) begin
                        tmr_q <= '0;
                        st_q <= UPDATE_MODE ? GSL_S_UPDATE : GSL_S_BLINK;
                    end
                end
                GSL_S_BLINK: begin
                    // a few short state flashes before the heartbeat
                    if (phase_end(tmr_q, 2 * HB_OFF_CYC)) begin
                        tmr_q <= '0;
                        blink_q <= blink_q + 1'b1;
                        if (blink_q == 4'(`GSL_PWRUP_BLINKS - 1)) begin
                            st_q <= GSL_S_RUN;
                        end
                    end
                end
                GSL_S_RUN: begin
                    if (phase_end(tmr_q, HB_PERIOD_CYC)) begin
                        tmr_q <= '0;
                    end
                end
                GSL_S_UPDATE: begin
                    tmr_q <= '0;
                end
                default: begin
                    st_q <= GSL_S_PWR_RED;
                    tmr_q <= '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // error code flasher: a burst of flashes then a gap, repeating
    // ****************************************************************
    localparam int unsigned EW = $clog2(ERR_FLASH_CYC + 1);
    logic [EW-1:0] etmr_q;
    logic [3:0] ephase_q;
    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            etmr_q <= '0;
            ephase_q <= '0;
        end else if (!fault_s) begin
            etmr_q <= '0;
            ephase_q <= '0;
        end else if (etmr_q == EW'(ERR_FLASH_CYC - 1)) begin
            etmr_q <= '0;
            // phases 0..2N-1 flash on/off, then the gap phases, all off
            if (ephase_q == 4'(2 * `GSL_ERR_FLASHES + `GSL_ERR_GAP_PHASES - 1)) begin
                ephase_q <= 4'h0;
            end else begin
                ephase_q <= ephase_q + 1'b1;
            end
        end else begin
            etmr_q <= etmr_q + 1'b1;
        end
    end
    logic err_on;
    assign err_on = fault_s && !ephase_q[0] && (ephase_q < 4'(2 * `GSL_ERR_FLASHES));

    // ****************************************************************
    // output registers
    // ****************************************************************
    logic pwr_show;
    assign pwr_show = (st_q == GSL_S_PWR_RED) || (st_q == GSL_S_PWR_GREEN);

    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            REQUEST_LED <= GSL_OFF;
            REPLY_LED <= GSL_OFF;
        end else if (st_q == GSL_S_PWR_RED) begin
            REQUEST_LED <= GSL_YELLOW;
            REPLY_LED <= GSL_RED;
        end else if (st_q == GSL_S_PWR_GREEN) begin
            REQUEST_LED <= GSL_GREEN;
            REPLY_LED <= GSL_GREEN;
        end else begin
            REQUEST_LED <= pick_color(1'b0, 1'b0, req_lit);
            REPLY_LED <= pick_color(bad_lit, good_lit, 1'b0);
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            ETH_TRAFFIC_LED <= 1'b0;
            ETH_LINK_LED <= 1'b0;
        end else begin
            ETH_TRAFFIC_LED <= !server_s || traf_lit;
            ETH_LINK_LED <= link_s;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            SERVICE_LED <= 1'b0;
            FIELDBUS_TRANSMIT_INDICATOR <= 1'b0;
            FIELDBUS_RECEIVE_INDICATOR <= 1'b0;
            USB_LED <= 1'b0;
        end else begin
            SERVICE_LED <= svc_lit || pwr_show;
            FIELDBUS_TRANSMIT_INDICATOR <= tx_lit;
            FIELDBUS_RECEIVE_INDICATOR <= rx_lit;
            USB_LED <= usb_s;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_q) begin
        if (!rst_q) begin
            STATE_LED <= 1'b0;
            ERROR_LED <= 1'b0;
        end else begin
            case (st_q)
                GSL_S_PWR_RED: begin
                    STATE_LED <= 1'b0;
                    ERROR_LED <= 1'b1;
                end
                GSL_S_PWR_GREEN: begin
                    STATE_LED <= 1'b1;
                    ERROR_LED <= 1'b0;
                end
                GSL_S_BLINK: begin
                    STATE_LED <= (tmr_q < CW'(HB_OFF_CYC));
                    ERROR_LED <= err_on;
                end
                GSL_S_RUN: begin
                    STATE_LED <= (tmr_q >= CW'(HB_OFF_CYC));
                    ERROR_LED <= err_on;
                end
                default: begin
                    STATE_LED <= 1'b0;
                    ERROR_LED <= err_on;
                end
            endcase
        end
    end
endmodule // gsl_indicator
`default_nettype wire

/* File: core/gsl_map.svh */
// constants for the gateway status indicator block
// Functional notes
// - master sent request: yellow request pulse
// - master good response: green reply pulse
// - master exception or timeout: red reply pulse
// - slave received request: yellow request pulse
// - slave valid normal reply: green reply pulse
// - slave exception, RTU CRC error: red reply
// - TCP connect failure: red reply only
// - traffic pulses; solid while server stopped
// - link indicator follows network connection
// - service message sent: yellow service pulse
// - fieldbus transmit: green transmit pulse
// - fieldbus receive: green receive pulse
// - heartbeat on, brief off every 2.5s
// - error off; fault flashes red code
// - USB connected lights green indicator
// - power-up flashes state and error indicators
// - update strap at power-up selects update mode
`ifndef GSL_MAP_SVH
`define GSL_MAP_SVH
`define GSL_CLK_HZ 50000000
`define GSL_PULSE_MS 50
`define GSL_PULSE_CYC ((`GSL_CLK_HZ / 1000) * `GSL_PULSE_MS)
`define GSL_HB_PERIOD_MS 2500
`define GSL_HB_PERIOD_CYC ((`GSL_CLK_HZ / 1000) * `GSL_HB_PERIOD_MS)
`define GSL_HB_OFF_MS 100
`define GSL_HB_OFF_CYC ((`GSL_CLK_HZ / 1000) * `GSL_HB_OFF_MS)
`define GSL_PWRUP_MS 500
`define GSL_PWRUP_CYC ((`GSL_CLK_HZ / 1000) * `GSL_PWRUP_MS)
`define GSL_ERR_FLASH_MS 250
`define GSL_ERR_FLASH_CYC ((`GSL_CLK_HZ / 1000) * `GSL_ERR_FLASH_MS)
`define GSL_ERR_FLASHES 3
`define GSL_PWRUP_BLINKS 3
`define GSL_ERR_GAP_PHASES 4
`define GSL_STRAP_SAMPLE_CYC 2
`endif

/* File: core/gsl_pkg.sv */
// types for the gateway status indicator block
package gsl_pkg;
    typedef enum logic [1:0] {GSL_OFF, GSL_YELLOW, GSL_GREEN, GSL_RED} gsl_color_t;
    typedef enum logic [2:0] {GSL_S_PWR_RED, GSL_S_PWR_GREEN, GSL_S_BLINK, GSL_S_RUN,
                              GSL_S_UPDATE} gsl_state_t;
endpackage

/* File: core/gsl_stretch.sv */
// pulse stretcher: one event strobe becomes a visible lit interval
`timescale 1ns/100ps
`default_nettype none
module gsl_stretch #(
    parameter int unsigned CYCLES = 2500000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic trig,
    output logic lit
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;
    // a new event reloads the count so it is never lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (trig) begin
            cnt_q <= W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign lit = (cnt_q != '0);
endmodule // gsl_stretch
`default_nettype wire

/* File: core/gsl_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module gsl_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            q <= '0;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule // gsl_sync
`default_nettype wire

/* File: tb/gsl_engine.sv */
// event source standing in for the protocol engines
`timescale 1ns/100ps
`default_nettype none
module gsl_engine (
    input wire logic clk,
    output logic [12:0] strobe
);
    initial strobe = 13'h0000;
    // one strobe per call, one cycle wide, launched just after an edge
    task automatic fire(input int unsigned idx);
        @(posedge clk);
        strobe <= 13'h0001 << idx;
        @(posedge clk);
        strobe <= 13'h0000;
    endtask
endmodule // gsl_engine
`default_nettype wire

/* File: tb/gsl_ind_chk.sv */
// assertion checker bound to the gateway status indicator top
`timescale 1ns/100ps
`default_nettype none
module gsl_ind_chk
    import gsl_pkg::*;
#(
    parameter int unsigned PULSE_CYC = 8,
    parameter int unsigned HB_PERIOD_CYC = 100,
    parameter int unsigned HB_OFF_CYC = 10
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic MASTER_REQ_SENT,
    input wire logic MASTER_RSP_GOOD,
    input wire logic MASTER_RSP_EXC,
    input wire logic MASTER_RSP_TIMEOUT,
    input wire logic SLAVE_REQ_RCVD,
    input wire logic SLAVE_RSP_GOOD,
    input wire logic SLAVE_RSP_EXC,
    input wire logic SLAVE_CRC_ERR,
    input wire logic RTU_MODE,
    input wire logic TCP_CONN_FAIL,
    input wire logic SERVER_RUNNING,
    input wire logic ETH_LINK,
    input wire logic HW_FAULT,
    input wire logic USB_CONNECTED,
    input wire gsl_pkg::gsl_color_t REQUEST_LED,
    input wire gsl_pkg::gsl_color_t REPLY_LED,
    input wire logic ETH_TRAFFIC_LED,
    input wire logic ETH_LINK_LED,
    input wire logic STATE_LED,
    input wire logic ERROR_LED,
    input wire logic USB_LED,
    input wire logic UPDATE_MODE
);
    // ****************
    // helper counters
    // ****************
    logic [7:0] up_q;
    logic [7:0] idle_q;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    // power-up show is over well before 160 cycles, so event checks wait for it
    wire run = (up_q == 8'hA0);
    wire red_ev = MASTER_RSP_EXC | MASTER_RSP_TIMEOUT | SLAVE_RSP_EXC | TCP_CONN_FAIL |
                  (SLAVE_CRC_ERR & RTU_MODE);
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) up_q <= 8'h00;
        else if (up_q != 8'hA0) up_q <= up_q + 8'h01;
    end
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) idle_q <= 8'hFF;
        else if (MASTER_REQ_SENT || SLAVE_REQ_RCVD) idle_q <= 8'h00;
        else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
    end
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else begin
            lo_q <= STATE_LED ? 8'h00 : lo_q + 8'h01;
            hi_q <= STATE_LED ? hi_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    a_req_yellow: assert property (run && (MASTER_REQ_SENT || SLAVE_REQ_RCVD) |->
        ##2 REQUEST_LED == GSL_YELLOW) else $error("request indicator not yellow");
    a_rep_green: assert property (run && (MASTER_RSP_GOOD || SLAVE_RSP_GOOD) && !red_ev &&
        !$past(red_ev) && REPLY_LED != GSL_RED |-> ##2 REPLY_LED == GSL_GREEN)
        else $error("reply indicator not green");
    a_rep_red: assert property (run && red_ev |-> ##2 REPLY_LED == GSL_RED)
        else $error("reply indicator not red");
    a_req_width: assert property (run && $past(REQUEST_LED) == GSL_OFF &&
        REQUEST_LED == GSL_YELLOW |-> (REQUEST_LED == GSL_YELLOW) [*8])
        else $error("request pulse too short");
    a_req_expires: assert property (run && idle_q == 8'(PULSE_CYC + 6) |->
        REQUEST_LED == GSL_OFF) else $error("request pulse too long");
    a_link_on: assert property (run && $rose(ETH_LINK) |-> ##[2:6] ETH_LINK_LED)
        else $error("link indicator not lit");
    a_traffic_solid: assert property (run && $fell(SERVER_RUNNING) ##1 !SERVER_RUNNING [*5]
        |-> ETH_TRAFFIC_LED) else $error("traffic indicator not solid");
    a_err_quiet: assert property ((run && !HW_FAULT) [*8] |-> !ERROR_LED)
        else $error("error indicator lit without fault");
    a_usb_on: assert property ((run && USB_CONNECTED) [*6] |-> USB_LED)
        else $error("usb indicator dark");
    a_heart_beat: assert property (run && !UPDATE_MODE |-> lo_q <= HB_OFF_CYC &&
        hi_q <= HB_PERIOD_CYC - HB_OFF_CYC) else $error("heartbeat timing off");
endmodule // gsl_ind_chk
bind gsl_indicator gsl_ind_chk #(.PULSE_CYC(PULSE_CYC), .HB_PERIOD_CYC(HB_PERIOD_CYC),
    .HB_OFF_CYC(HB_OFF_CYC)) u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .MASTER_REQ_SENT(MASTER_REQ_SENT), .MASTER_RSP_GOOD(MASTER_RSP_GOOD),
    .MASTER_RSP_EXC(MASTER_RSP_EXC), .MASTER_RSP_TIMEOUT(MASTER_RSP_TIMEOUT),
    .SLAVE_REQ_RCVD(SLAVE_REQ_RCVD), .SLAVE_RSP_GOOD(SLAVE_RSP_GOOD),
    .SLAVE_RSP_EXC(SLAVE_RSP_EXC), .SLAVE_CRC_ERR(SLAVE_CRC_ERR), .RTU_MODE(RTU_MODE),
    .TCP_CONN_FAIL(TCP_CONN_FAIL), .SERVER_RUNNING(SERVER_RUNNING), .ETH_LINK(ETH_LINK),
    .HW_FAULT(HW_FAULT), .USB_CONNECTED(USB_CONNECTED), .REQUEST_LED(REQUEST_LED),
    .REPLY_LED(REPLY_LED), .ETH_TRAFFIC_LED(ETH_TRAFFIC_LED), .ETH_LINK_LED(ETH_LINK_LED),
    .STATE_LED(STATE_LED), .ERROR_LED(ERROR_LED), .USB_LED(USB_LED),
    .UPDATE_MODE(UPDATE_MODE));
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the gateway status indicator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gsl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rtu, srv, link, fault, usb, strap;
    logic [12:0] st;
    gsl_color_t req_led, rep_led;
    logic eth_t, eth_l, svc, ftx, frx, state, err, usb_led, upd;
    int miscompares = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    gsl_engine eng (.clk(clk), .strobe(st));
    gsl_indicator #(.PULSE_CYC(8), .HB_PERIOD_CYC(100), .HB_OFF_CYC(10), .PWRUP_CYC(20),
        .ERR_FLASH_CYC(5)) dut (.CLK_SYS(clk), .RST_B(rst_b), .MASTER_REQ_SENT(st[0]),
        .MASTER_RSP_GOOD(st[1]), .MASTER_RSP_EXC(st[2]), .MASTER_RSP_TIMEOUT(st[3]),
        .SLAVE_REQ_RCVD(st[4]), .SLAVE_RSP_GOOD(st[5]), .SLAVE_RSP_EXC(st[6]),
        .SLAVE_CRC_ERR(st[7]), .RTU_MODE(rtu), .TCP_CONN_FAIL(st[8]), .ETH_TRAFFIC(st[9]),
        .SERVER_RUNNING(srv), .ETH_LINK(link), .SERVICE_MSG_TX(st[10]), .FIELDBUS_TX(st[11]),
        .FIELDBUS_RX(st[12]), .HW_FAULT(fault), .USB_CONNECTED(usb), .UPDATE_STRAP(strap),
        .REQUEST_LED(req_led), .REPLY_LED(rep_led), .ETH_TRAFFIC_LED(eth_t),
        .ETH_LINK_LED(eth_l), .SERVICE_LED(svc), .FIELDBUS_TRANSMIT_INDICATOR(ftx),
        .FIELDBUS_RECEIVE_INDICATOR(frx), .STATE_LED(state), .ERROR_LED(err),
        .USB_LED(usb_led), .UPDATE_MODE(upd));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic cmp_col(input string what, input gsl_color_t exp, input gsl_color_t got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_b <= 1'b0;
        strap <= s;
        rtu <= 1'b1;
        srv <= 1'b1;
        link <= 1'b0;
        fault <= 1'b0;
        usb <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic t_powerup;
        wt(8);
        cmp_col("reply", GSL_RED, rep_led);
        cmp_bit("error", 1'b1, err);
        wt(20);
        cmp_col("request", GSL_GREEN, req_led);
        cmp_bit("state", 1'b1, state);
        wt(140);
    endtask
    task automatic t_request;
        eng.fire(0);
        wt(2);
        cmp_col("request", GSL_YELLOW, req_led);
        eng.fire(4);
        wt(7);
        cmp_col("request", GSL_YELLOW, req_led);
        wt(6);
        cmp_col("request", GSL_OFF, req_led);
    endtask
    task automatic t_reply;
        int unsigned idx[8] = '{1, 2, 3, 5, 6, 7, 8, 7};
        gsl_color_t col[8] = '{GSL_GREEN, GSL_RED, GSL_RED, GSL_GREEN, GSL_RED, GSL_RED,
                               GSL_RED, GSL_OFF};
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                @(posedge clk);
                rtu <= 1'b0;
                wt(4);
            end
            eng.fire(idx[i]);
            wt(3);
            cmp_col("reply", col[i], rep_led);
            cmp_col("request", GSL_OFF, req_led);
            wt(12);
        end
        @(posedge clk);
        rtu <= 1'b1;
    endtask
    task automatic t_diag;
        eng.fire(10);
        wt(2);
        cmp_bit("service", 1'b1, svc);
        eng.fire(11);
        wt(2);
        cmp_bit("fieldbus tx", 1'b1, ftx);
        eng.fire(12);
        wt(2);
        cmp_bit("fieldbus rx", 1'b1, frx);
        eng.fire(9);
        wt(2);
        cmp_bit("traffic", 1'b1, eth_t);
        wt(12);
        cmp_bit("traffic", 1'b0, eth_t);
        cmp_bit("fieldbus rx", 1'b0, frx);
        @(posedge clk);
        srv <= 1'b0;
        wt(30);
        cmp_bit("traffic", 1'b1, eth_t);
        @(posedge clk);
        srv <= 1'b1;
    endtask
    task automatic t_levels;
        int n = 0;
        logic prev = 1'b0;
        @(posedge clk);
        link <= 1'b1;
        usb <= 1'b1;
        fault <= 1'b1;
        wt(6);
        cmp_bit("link", 1'b1, eth_l);
        cmp_bit("usb", 1'b1, usb_led);
        // a full code with its gap fits in 60 cycles at the shortened flash time
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            if (err && !prev) n++;
            prev = err;
        end
        cmp_bit("error flashes", 1'b1, logic'(n >= 3));
        @(posedge clk);
        link <= 1'b0;
        usb <= 1'b0;
        fault <= 1'b0;
        wt(12);
        cmp_bit("link", 1'b0, eth_l);
        cmp_bit("error", 1'b0, err);
        cmp_bit("usb", 1'b0, usb_led);
    endtask
    task automatic t_heartbeat;
        int n = 0;
        logic prev = 1'b1;
        for (int i = 0; i < 250; i++) begin
            @(negedge clk);
            if (prev && !state) n++;
            prev = state;
        end
        cmp_bit("heartbeat", 1'b1, logic'(n >= 2 && n <= 3));
    endtask
    task automatic t_update;
        do_reset(1'b1);
        wt(200);
        cmp_bit("update mode", 1'b1, upd);
        cmp_bit("state", 1'b0, state);
        do_reset(1'b0);
        wt(200);
        cmp_bit("update mode", 1'b0, upd);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        t_powerup;
        t_request;
        t_reply;
        t_diag;
        t_levels;
        t_heartbeat;
        t_update;
        tally_and_finish;
    end
    initial begin
        // the sequence needs about 1150 cycles
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
